// ===== rtl/sws_fault_filter.sv
// Persistence filter for one output fault condition
`timescale 1ns/1ps
`default_nettype none
module sws_fault_filter #(
  parameter int unsigned CNT_W = 17,
  parameter int unsigned QUAL  = 20000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic raw_fault,
  output logic      fault_q
);
  logic [CNT_W-1:0] cnt_q;

  // Count only while the raw condition persists; a glitch restarts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!raw_fault) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_W'(QUAL)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= raw_fault && (cnt_q == CNT_W'(QUAL));
    end
  end
endmodule : sws_fault_filter
`default_nettype wire

// ===== rtl/sws_pkg.sv
// Shared constants for the serial switch control block
package sws_pkg;
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned NUM_OUT        = 16;
  localparam int unsigned BIT_ANY_FAULT  = 23;
  localparam int unsigned BIT_OVERVOLT   = 22;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned MAX_SCLK_KHZ   = 6000;
  localparam int unsigned FLT_MIN_US     = 100;
  localparam int unsigned FLT_MAX_US     = 450;
  localparam int unsigned FLT_MIN_CYC    = FLT_MIN_US * CLK_MHZ;
  localparam int unsigned FLT_MAX_CYC    = FLT_MAX_US * CLK_MHZ;
  localparam int unsigned FLT_CNT_W      = 17;
  localparam logic [15:0] OUT_RESET      = 16'h0000;
  localparam logic [23:0] FRAME_RESET    = 24'h00_0000;
endpackage : sws_pkg

// ===== rtl/sws_spi_ctrl.sv
// SPI control and fault readout for a 16-output low-side switch
`timescale 1ns/1ps
`default_nettype none
module sws_spi_ctrl
  import sws_pkg::*;
#(
  parameter int unsigned FLT_QUAL_CYC = sws_pkg::FLT_MIN_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  input  wire logic [15:0] short_on,
  input  wire logic [15:0] open_off,
  input  wire logic        overvolt,
  output logic [15:0]      out_on,
  output logic [23:0]      cmd_word,
  output logic             cmd_strobe
);
  import sws_pkg::*;

  logic        rst_s1_q, rst_n_q;
  logic [1:0]  sclk_s_q, cs_s_q, sdi_s_q, ov_s_q;
  logic [15:0] sh_s1_q, sh_s2_q, op_s1_q, op_s2_q;
  logic        sclk_prev_q, cs_prev_q;
  logic        sclk_rise, sclk_fall, cs_rise, cs_fall, sel;
  logic [23:0] rx_q, tx_q;
  logic [15:0] flt_q;
  logic        ov_flt_q;
  logic        load_q;

  // Reset released through two stages
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Pin synchronisers; sampling at 200 MHz covers a 6 MHz SCLK
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_s_q <= 2'h0;
      cs_s_q   <= 2'h3;
      sdi_s_q  <= 2'h0;
      ov_s_q   <= 2'h0;
      sh_s1_q  <= 16'h0000;
      sh_s2_q  <= 16'h0000;
      op_s1_q  <= 16'h0000;
      op_s2_q  <= 16'h0000;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk};
      cs_s_q   <= {cs_s_q[0], cs_n};
      sdi_s_q  <= {sdi_s_q[0], sdi};
      ov_s_q   <= {ov_s_q[0], overvolt};
      sh_s1_q  <= short_on;
      sh_s2_q  <= sh_s1_q;
      op_s1_q  <= open_off;
      op_s2_q  <= op_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s_q[1];
      cs_prev_q   <= cs_s_q[1];
    end
  end

  assign sel       = !cs_s_q[1];
  assign sclk_rise = sel && sclk_s_q[1] && !sclk_prev_q;
  assign sclk_fall = sel && !sclk_s_q[1] && sclk_prev_q;
  assign cs_fall   = cs_prev_q && !cs_s_q[1];
  assign cs_rise   = !cs_prev_q && cs_s_q[1];

  // Fault qualification per output
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_flt
    sws_fault_filter #(
      .CNT_W (FLT_CNT_W),
      .QUAL  (FLT_QUAL_CYC)
    ) u_flt (
      .clock     (clock),
      .rst_n     (rst_n_q),
      .raw_fault (sh_s2_q[i] || op_s2_q[i]),
      .fault_q   (flt_q[i])
    );
  end

  // Overvoltage reported as soon as the synchronised level shows it
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ov_flt_q <= 1'b0;
    end else begin
      ov_flt_q <= ov_s_q[1];
    end
  end

  // Input shifter: sample on falling SCLK, MSB enters first
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_q <= FRAME_RESET;
    end else if (sclk_fall) begin
      rx_q <= {rx_q[22:0], sdi_s_q[1]};
    end
  end

  // Output shifter: load on select fall, shift on falling SCLK
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_q <= FRAME_RESET;
    end else if (cs_fall) begin
      tx_q <= {(|flt_q) || ov_flt_q, ov_flt_q, 6'h00, flt_q};
    end else if (sclk_fall) begin
      // Same sample as the input shifter, so chained data trails by 24 bits
      tx_q <= {tx_q[22:0], sdi_s_q[1]};
    end
  end

  // Driver latch; only the last 24 bits count
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_on     <= OUT_RESET;
      cmd_word   <= FRAME_RESET;
      cmd_strobe <= 1'b0;
    end else begin
      cmd_strobe <= cs_rise;
      if (cs_rise) begin
        cmd_word <= rx_q;
        // Plain on/off command: high bit turns output on
        if (rx_q[23:18] == 6'h00) begin
          out_on <= rx_q[15:0];
        end
      end
    end
  end

  // SO moves only on load or rising SCLK, so it stands across the fall
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
      load_q   <= 1'b0;
    end else begin
      load_q   <= cs_fall;
      if (load_q || sclk_rise) begin
        sdo <= tx_q[23];
      end
      sdo_oe_n <= !sel;
    end
  end

  drv_latch_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cs_rise && (rx_q[23:18] == 6'h00) |=> out_on == $past(rx_q[15:0]))
    else $error("driver latch missed select rise");
  status_load_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cs_fall |=> tx_q[21:16] == 6'h00 && tx_q[15:0] == $past(flt_q))
    else $error("status frame not loaded");
  any_fault_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cs_fall |=> tx_q[23] == ((|tx_q[15:0]) || tx_q[22]))
    else $error("any-fault bit wrong");
  sdo_float_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cs_s_q[1] |=> sdo_oe_n)
    else $error("serial output driven while deselected");
  rx_idle_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cs_s_q[1] |=> $stable(rx_q))
    else $error("input shifter moved while deselected");
  rx_shift_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    sclk_fall |=> rx_q[0] == $past(sdi_s_q[1]) && rx_q[23:1] == $past(rx_q[22:0]))
    else $error("input shift wrong");
  tx_shift_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    sclk_fall && !cs_fall |=> tx_q[23:1] == $past(tx_q[22:0])
    && tx_q[0] == $past(sdi_s_q[1]))
    else $error("output shift wrong");
  fault_flag_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    $rose(flt_q[0]) |-> $past(sh_s2_q[0] || op_s2_q[0], 2))
    else $error("fault set without cause");
  strobe_a: assert property (@(posedge clock) disable iff (!rst_n_q)
    cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
endmodule : sws_spi_ctrl
`default_nettype wire

// ===== tb/sws_spi_ctrl_tb.sv
// Self-checking bench for the serial switch control block
`timescale 1ns/1ps
`default_nettype none
module sws_spi_ctrl_tb;
  import sws_pkg::*;
  localparam int QUAL = 20;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, cmd_strobe;
  logic        overvolt = 1'b0;
  logic [15:0] short_on = '0;
  logic [15:0] open_off = '0;
  logic [15:0] out_on, f;
  logic [15:0] exp_on = '0;
  logic [23:0] cmd_word, b, keep;
  logic [47:0] rx;
  logic [31:0] seed = 32'hb147_ab87;
  int          bad_count = 0;
  int          n_checks = 0;
  always #2.5 clock = ~clock;
  sws_spi_ctrl #(.FLT_QUAL_CYC(QUAL)) u_sws_spi_ctrl (.clock(clock),
    .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .short_on(short_on), .open_off(open_off),
    .overvolt(overvolt), .out_on(out_on), .cmd_word(cmd_word),
    .cmd_strobe(cmd_strobe));
  sws_spi_master u_sws_spi_master (.clock(clock), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo)); // One select per device
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [23:0] status(logic [15:0] flt, logic ov);
    return {(|flt) | ov, ov, 6'h00, flt};
  endfunction : status
  task automatic chk(string what, logic [47:0] e, logic [47:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Two chained frames: the second one is acted on
  task automatic frame(logic [23:0] a, logic [23:0] c, logic [15:0] flt);
    int n;
    n = 0;
    u_sws_spi_master.xfer({a, c}, 48, rx);
    while (cmd_strobe !== 1'b1 && n < 12) begin
      @(negedge clock);
      n++;
    end
    if (n == 12) begin
      bad_count++;
      conclude();
    end
    if (c[23:18] == 6'h00) exp_on = c[15:0];
    chk("status", status(flt, overvolt), rx[47:24]);
    chk("passthru", a, rx[23:0]);
    chk("cmd_word", c, cmd_word);
    chk("out_on", exp_on, out_on);
    @(negedge clock);
    chk("strobe", 0, cmd_strobe);
  endtask : frame
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    open_off = 16'hffff; // Too brief to qualify
    repeat (QUAL / 2) @(negedge clock);
    open_off = '0;
    repeat (100) @(negedge clock);
    frame(24'h00_ffff, 24'h00_a5c3, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      f = 16'(rnd());
      short_on = f & exp_on;
      open_off = f & ~exp_on;
      overvolt = (i % 4 == 3);
      repeat (5 * QUAL) @(negedge clock); // Access spacing
      b = 24'(rnd());
      if (i % 3 != 0) b[23:18] = 6'h00;
      frame(24'(rnd()), b, f);
      keep = cmd_word;
      u_sws_spi_master.noise(rnd());
      repeat (8) @(negedge clock);
      chk("idle cmd", keep, cmd_word);
      chk("idle oe_n", 1, sdo_oe_n);
    end
    conclude();
  end
endmodule : sws_spi_ctrl_tb
`default_nettype wire

// ===== tb/sws_spi_master.sv
// SPI master model for the switch control pins
`timescale 1ns/1ps
`default_nettype none
module sws_spi_master #(
  parameter int HALF = 17
) (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // High phase of 17 clocks and low phase of 34 keep SCLK under 6 MHz
  task automatic xfer(input logic [47:0] tx, input int nb,
                      output logic [47:0] rx);
    rx = '0;
    @(negedge clock) cs_n = 1'b0;
    repeat (HALF) @(negedge clock);
    for (int i = nb - 1; i >= 0; i--) begin // 24 per device, MSB first
      sdi = tx[i];
      repeat (HALF) @(negedge clock);
      sclk = 1'b1; // Device shifts out on rise
      repeat (HALF) @(negedge clock);
      rx[i] = sdo;
      sclk = 1'b0; // Device samples on fall
      repeat (HALF) @(negedge clock); // SI hold after the fall
    end
    repeat (HALF) @(negedge clock);
    cs_n = 1'b1;
    sdi = 1'b0; // Pull-down level once released
  endtask : xfer
  // Clock and data wiggle while deselected
  task automatic noise(input logic [31:0] r);
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      sclk = r[i];
      sdi = r[i+16];
    end
    @(negedge clock) sclk = 1'b0; // SCLK low before any select edge
  endtask : noise
endmodule : sws_spi_master
`default_nettype wire
